// >>> inc/csd_cfg.svh
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CSD_DATA_W        16
`define CSD_ADDR_W        18
`define CSD_PTR_W         9
`define CSD_PS_W          8

// ----------------------------------------
// Bus address decode
// ----------------------------------------
`define CSD_ADR_PS        18'h3FFFE
`define CSD_ADR_SLR       18'h3FFFC
`define CSD_ADR_REG_BASE  18'h3FFC0
`define CSD_ADR_SWR       18'h3FF78
`define CSD_STK_YEL_TOP   16'h00FF
`define CSD_STK_RED_GAP   16'h0020

// ----------------------------------------
// Forced pointer addresses
// ----------------------------------------
`define CSD_VEC_PWR       9'h001
`define CSD_VEC_INIT      9'h002
`define CSD_VEC_BERR      9'h004
`define CSD_VEC_STK       9'h008

// ----------------------------------------
// Software registers (byte offsets)
// ----------------------------------------
`define CSD_OFS_STATUS    4'h0
`define CSD_OFS_MASK      4'h4
`define CSD_OFS_CTRL      4'h8
`define CSD_OFS_INFO      4'hC
`define CSD_EV_W          5
`define CSD_EV_PWR        0
`define CSD_EV_INIT       1
`define CSD_EV_BERR       2
`define CSD_EV_RED        3
`define CSD_EV_YEL        4
`define CSD_CTRL_RST      2'h3

`endif

// >>> inc/csd_pkg.sv
package csd_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_JAM,
    ST_FETCH
  } csd_jam_e;
  typedef logic [8:0] csd_ptr_t;
endpackage

// >>> rtl/csd_instr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "csd_cfg.svh"

module csd_instr_decode (
  input  wire logic [15:0] i_ir,
  input  wire logic [3:0]  i_cc,
  output logic             o_dbl_op,
  output logic             o_sgl_op,
  output logic             o_branch_op,
  output logic             o_byte_op,
  output logic [3:0]       o_alu_func,
  output logic [2:0]       o_branch_test_sel,
  output logic             o_branch_cond
);
  // ----------------------------------------
  // Format and opcode classes
  // ----------------------------------------
  wire logic [2:0] op_hi;
  wire logic       cc_n;
  wire logic       cc_z;
  wire logic       cc_v;
  wire logic       cc_c;
  logic            cond;

  assign op_hi = i_ir[14:12];
  assign o_dbl_op = (op_hi != 3'h0) && (op_hi != 3'h7);
  assign o_sgl_op = (op_hi == 3'h0) && i_ir[11];
  assign o_branch_op = (op_hi == 3'h0) && !i_ir[11] && (i_ir[10:8] != 3'h0);
  assign o_byte_op = i_ir[15];
  assign o_alu_func = o_dbl_op ? {1'b0, op_hi} :
                      o_sgl_op ? {1'b1, i_ir[8:6]} : 4'h0;
  assign o_branch_test_sel = o_branch_op ? {i_ir[15], i_ir[10:9]} : 3'h0;

  // ----------------------------------------
  // Branch condition from status bits
  // ----------------------------------------
  assign cc_n = i_cc[3];
  assign cc_z = i_cc[2];
  assign cc_v = i_cc[1];
  assign cc_c = i_cc[0];

  always_comb begin
    case ({i_ir[15], i_ir[10:9]})
      3'h0:    cond = 1'b1;
      3'h1:    cond = !cc_z;
      3'h2:    cond = !(cc_n ^ cc_v);
      3'h3:    cond = !(cc_z || (cc_n ^ cc_v));
      3'h4:    cond = !cc_n;
      3'h5:    cond = !(cc_c || cc_z);
      3'h6:    cond = !cc_v;
      3'h7:    cond = !cc_c;
      default: cond = 1'b0;
    endcase
  end

  assign o_branch_cond = o_branch_op && (i_ir[8] ? !cond : cond); // [R14]
endmodule
`default_nettype wire

// >>> rtl/csd_core.sv
// Contract
// R1: Display shows inverted data select mux
// R2: Decode bus address into register selects
// R3: Sense stack overflow; flag and halt
// R4: Zero detect on D register contents
// R5: Basic and expansion pointer copies driven
// R6: 16-bit instruction register loads at fetch
// R7: Some instruction bits bypass the decoder
// R8: Decoder drives ALU, branch, test select
// R9: Force pointer on four exceptional events
// R10: Load microword buffer after forced pointer
// R11: Status register has eight flip-flops
// R12: Status loads from mux or condition logic
// R13: Status gated onto system or read bus
// R14: Status bits feed branch and microbranch
// R15: Previous pointer latch captures every clock
// R16: One clock; forcing beats normal sequencing
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "csd_cfg.svh"

module csd_core (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic [15:0] I_DMUX_DATA,
  input  wire logic [15:0] I_D_REG,
  input  wire logic [17:0] I_BUS_ADDR,
  input  wire logic        I_STACK_REF,
  input  wire logic [7:0]  I_STACK_LIMIT,
  input  wire logic [8:0]  I_POINTER_NEXT,
  input  wire logic        I_IR_LOAD,
  input  wire logic        I_PS_LOAD_DMUX,
  input  wire logic        I_PS_LOAD_CC,
  input  wire logic [3:0]  I_CC_IN,
  input  wire logic        I_PS_TO_BUS,
  input  wire logic        I_PS_TO_RD,
  input  wire logic        I_BUS_ERROR,
  input  wire logic        I_POWER_UP_RESTART,
  input  wire logic        I_CONSOLE_INIT,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             O_IRQ,
  output logic [15:0]      O_DATA_DISPLAY,
  output logic             O_SEL_PS,
  output logic             O_SEL_SLR,
  output logic             O_SEL_SCRATCH,
  output logic             O_SEL_SWITCH,
  output logic             O_STACK_OVERFLOW_FLAG,
  output logic             O_STACK_OVERFLOW_HALT,
  output logic             O_D_ZERO,
  output logic [8:0]       O_BASIC_POINTER_COPY,
  output logic [8:0]       O_EXPANSION_POINTER_COPY,
  output logic [8:0]       O_PREVIOUS_POINTER_LATCH,
  output logic [15:0]      O_INSTRUCTION_WORD,
  output logic [2:0]       O_IR_SRC_REG,
  output logic [2:0]       O_IR_DST_REG,
  output logic [7:0]       O_IR_BRANCH_OFFSET,
  output logic             O_DBL_OP,
  output logic             O_SGL_OP,
  output logic             O_BRANCH_OP,
  output logic             O_BYTE_OP,
  output logic [3:0]       O_ALU_FUNC,
  output logic [2:0]       O_BRANCH_TEST_SELECT,
  output logic             O_BRANCH_COND,
  output logic [7:0]       O_PROCESSOR_STATUS_WORD,
  output logic [7:0]       O_BUS_D,
  output logic             O_BUS_D_OE,
  output logic [7:0]       O_BUS_RD,
  output logic             O_BUS_RD_OE,
  output logic             O_FORCED_POINTER_LOAD,
  output logic             O_UWORD_LOAD
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rise(input logic now, input logic was);
    rise = now && !was;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and event edges
  // ----------------------------------------
  logic [1:0] pwr_sync;
  logic [1:0] init_sync;
  logic       pwr_q;
  logic       init_q;
  logic       berr_q;
  logic       red_q;
  logic       yel_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pwr_sync  <= 2'h0;
      init_sync <= 2'h0;
      pwr_q     <= 1'b0;
      init_q    <= 1'b0;
      berr_q    <= 1'b0;
      red_q     <= 1'b0;
      yel_q     <= 1'b0;
    end else begin
      pwr_sync  <= {pwr_sync[0], I_POWER_UP_RESTART};
      init_sync <= {init_sync[0], I_CONSOLE_INIT};
      pwr_q     <= pwr_sync[1];
      init_q    <= init_sync[1];
      berr_q    <= I_BUS_ERROR;
      red_q     <= O_STACK_OVERFLOW_HALT;
      yel_q     <= O_STACK_OVERFLOW_FLAG;
    end
  end

  // ----------------------------------------
  // Address and data decode
  // ----------------------------------------
  logic [1:0]  ctrl;
  wire  [15:0] stack_top;
  wire  [15:0] red_top;
  wire         stk_check;

  assign O_SEL_PS      = (I_BUS_ADDR == `CSD_ADR_PS); // [R2]
  assign O_SEL_SLR     = (I_BUS_ADDR == `CSD_ADR_SLR); // [R2]
  assign O_SEL_SCRATCH = (I_BUS_ADDR[17:4] == 14'(`CSD_ADR_REG_BASE >> 4)); // [R2]
  assign O_SEL_SWITCH  = (I_BUS_ADDR == `CSD_ADR_SWR); // [R2]

  // Yellow zone below limit, red zone further below
  assign stack_top = {I_STACK_LIMIT, 8'h00} | `CSD_STK_YEL_TOP;
  assign red_top   = (stack_top > `CSD_STK_RED_GAP) ?
                     stack_top - `CSD_STK_RED_GAP : 16'h0000;
  assign stk_check = I_STACK_REF && ctrl[1];
  assign O_STACK_OVERFLOW_FLAG = stk_check && (I_BUS_ADDR[15:0] <= stack_top); // [R3]
  assign O_STACK_OVERFLOW_HALT = stk_check && (I_BUS_ADDR[15:0] < red_top); // [R3]
  assign O_D_ZERO = (I_D_REG == 16'h0000); // [R4]

  // ----------------------------------------
  // Console display
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DATA_DISPLAY <= 16'hFFFF;
    end else begin
      O_DATA_DISPLAY <= ~I_DMUX_DATA; // [R1]
    end
  end

  // ----------------------------------------
  // Instruction register and decode
  // ----------------------------------------
  logic [15:0] ir;
  logic [7:0]  ps;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ir <= 16'h0000;
    end else if (I_IR_LOAD) begin
      ir <= I_DMUX_DATA; // [R6]
    end
  end

  assign O_INSTRUCTION_WORD = ir;
  assign O_IR_SRC_REG       = ir[8:6]; // [R7]
  assign O_IR_DST_REG       = ir[2:0]; // [R7]
  assign O_IR_BRANCH_OFFSET = ir[7:0]; // [R7]

  csd_instr_decode u_decode (
    .i_ir              (ir),
    .i_cc              (ps[3:0]),
    .o_dbl_op          (O_DBL_OP),
    .o_sgl_op          (O_SGL_OP),
    .o_branch_op       (O_BRANCH_OP),
    .o_byte_op         (O_BYTE_OP),
    .o_alu_func        (O_ALU_FUNC),
    .o_branch_test_sel (O_BRANCH_TEST_SELECT),
    .o_branch_cond     (O_BRANCH_COND)
  ); // [R8]

  // ----------------------------------------
  // Processor status register
  // ----------------------------------------
  wire  [7:0] next_ps;

  assign next_ps = I_PS_LOAD_DMUX ? I_DMUX_DATA[7:0] : // [R12]
                   {ps[7:4], I_CC_IN};

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ps <= 8'h00; // [R11]
    end else if (I_PS_LOAD_DMUX || I_PS_LOAD_CC) begin
      ps <= next_ps; // [R12]
    end
  end

  assign O_PROCESSOR_STATUS_WORD = ps; // [R14]
  assign O_BUS_D     = I_PS_TO_BUS ? ps : 8'h00; // [R13]
  assign O_BUS_D_OE  = I_PS_TO_BUS; // [R13]
  assign O_BUS_RD    = I_PS_TO_RD ? ps : 8'h00; // [R13]
  assign O_BUS_RD_OE = I_PS_TO_RD; // [R13]

  // ----------------------------------------
  // Forced pointer sequencer
  // ----------------------------------------
  csd_pkg::csd_jam_e state;
  csd_pkg::csd_jam_e next_state;
  csd_pkg::csd_ptr_t pointer;
  csd_pkg::csd_ptr_t prev_ptr;
  csd_pkg::csd_ptr_t force_vec;
  wire  [4:0] ev;
  wire        force_req;
  wire  [8:0] next_pointer;

  assign ev[`CSD_EV_PWR]  = rise(pwr_sync[1], pwr_q);
  assign ev[`CSD_EV_INIT] = rise(init_sync[1], init_q);
  assign ev[`CSD_EV_BERR] = rise(I_BUS_ERROR, berr_q);
  assign ev[`CSD_EV_RED]  = rise(O_STACK_OVERFLOW_HALT, red_q);
  assign ev[`CSD_EV_YEL]  = rise(O_STACK_OVERFLOW_FLAG, yel_q);

  assign force_req = ctrl[0] && (state == csd_pkg::ST_RUN) &&
                     (|ev[`CSD_EV_RED:`CSD_EV_PWR]); // [R9]
  assign force_vec = ev[`CSD_EV_PWR]  ? `CSD_VEC_PWR :
                     ev[`CSD_EV_INIT] ? `CSD_VEC_INIT :
                     ev[`CSD_EV_BERR] ? `CSD_VEC_BERR :
                     `CSD_VEC_STK; // [R9]
  assign next_pointer = force_req ? force_vec : I_POINTER_NEXT; // [R16]

  always_comb begin
    next_state = state;
    case (state)
      csd_pkg::ST_RUN:   next_state = force_req ? csd_pkg::ST_JAM : csd_pkg::ST_RUN;
      csd_pkg::ST_JAM:   next_state = csd_pkg::ST_FETCH;
      csd_pkg::ST_FETCH: next_state = csd_pkg::ST_RUN;
      default:           next_state = csd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state    <= csd_pkg::ST_RUN;
      pointer  <= 9'h000;
      prev_ptr <= 9'h000;
    end else begin
      state    <= next_state;
      pointer  <= next_pointer; // [R16]
      prev_ptr <= pointer; // [R15]
    end
  end

  assign O_FORCED_POINTER_LOAD    = (state == csd_pkg::ST_JAM); // [R9]
  assign O_UWORD_LOAD             = (state == csd_pkg::ST_FETCH); // [R10]
  assign O_BASIC_POINTER_COPY     = pointer; // [R5]
  assign O_EXPANSION_POINTER_COPY = pointer; // [R5]
  assign O_PREVIOUS_POINTER_LATCH = prev_ptr; // [R15]

  // ----------------------------------------
  // Avalon-MM slave and interrupts
  // ----------------------------------------
  logic [4:0]  status;
  logic [4:0]  mask;
  logic        ack;
  wire         req;
  wire         wr_go;
  wire         wr_stat;
  wire         wr_mask;
  wire         wr_ctrl;
  wire  [31:0] rd_mux;
  wire  [4:0]  next_status;

  assign req     = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack;
  assign wr_go   = AVS_WRITE && ack;
  assign wr_stat = wr_go && (AVS_ADDRESS == `CSD_OFS_STATUS);
  assign wr_mask = wr_go && (AVS_ADDRESS == `CSD_OFS_MASK);
  assign wr_ctrl = wr_go && (AVS_ADDRESS == `CSD_OFS_CTRL);

  assign rd_mux =
    (AVS_ADDRESS == `CSD_OFS_STATUS) ? {27'h0, status} :
    (AVS_ADDRESS == `CSD_OFS_MASK)   ? {27'h0, mask} :
    (AVS_ADDRESS == `CSD_OFS_CTRL)   ? {30'h0, ctrl} :
    (AVS_ADDRESS == `CSD_OFS_INFO)   ? {5'h0, prev_ptr, pointer, ps, 1'b0} :
    32'h0000_0000;

  // Set wins over write-one-to-clear
  assign next_status = (status & ~(wr_stat ? AVS_WRITEDATA[4:0] : 5'h00)) | ev;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack          <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
      status       <= 5'h00;
      mask         <= 5'h00;
      ctrl         <= `CSD_CTRL_RST;
    end else begin
      ack    <= req && !ack;
      status <= next_status;
      if (req && !ack) begin
        AVS_READDATA <= rd_mux;
      end
      if (wr_mask) begin
        mask <= AVS_WRITEDATA[4:0];
      end
      if (wr_ctrl) begin
        ctrl <= AVS_WRITEDATA[1:0];
      end
    end
  end

  assign O_IRQ = |(status & mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_display_invert: assert property ( // [R1]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    1'b1 |=> (O_DATA_DISPLAY == ~$past(I_DMUX_DATA)))
    else $error("display not inverted mux");

  chk_ps_select: assert property ( // [R2]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_BUS_ADDR == 18'h3FFFE) |-> (O_SEL_PS && !O_SEL_SWITCH && !O_SEL_SLR))
    else $error("status word select wrong");

  chk_halt_flag: assert property ( // [R3]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_STACK_OVERFLOW_HALT |-> O_STACK_OVERFLOW_FLAG)
    else $error("halt without overflow flag");

  chk_zero_detect: assert property ( // [R4]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_D_ZERO == (I_D_REG == 16'h0000))
    else $error("zero detect wrong");

  chk_ir_load: assert property ( // [R6]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_IR_LOAD |=> (O_INSTRUCTION_WORD == $past(I_DMUX_DATA)))
    else $error("instruction not loaded");

  chk_ir_hold: assert property ( // [R6]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !I_IR_LOAD |=> $stable(O_INSTRUCTION_WORD))
    else $error("instruction changed without load");

  chk_ps_mux_load: assert property ( // [R12]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_PS_LOAD_DMUX |=> (O_PROCESSOR_STATUS_WORD == $past(I_DMUX_DATA[7:0])))
    else $error("status not loaded from mux");

  chk_ps_bus_gate: assert property ( // [R13]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_PS_TO_BUS |-> (O_BUS_D_OE && O_BUS_D == O_PROCESSOR_STATUS_WORD))
    else $error("status not gated to bus");

  chk_pwr_force: assert property ( // [R9]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (force_req && ev[`CSD_EV_PWR]) |=> (O_BASIC_POINTER_COPY == 9'h001) ##0 O_FORCED_POINTER_LOAD)
    else $error("power restart vector not forced");

  chk_uword_timing: assert property ( // [R10]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    force_req |=> O_FORCED_POINTER_LOAD ##1 (O_UWORD_LOAD && !O_FORCED_POINTER_LOAD) ##1 !O_UWORD_LOAD)
    else $error("microword load timing wrong");

  chk_prev_latch: assert property ( // [R15]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    1'b1 |=> (O_PREVIOUS_POINTER_LATCH == $past(O_BASIC_POINTER_COPY)))
    else $error("previous pointer not captured");

  chk_copies_equal: assert property ( // [R5]
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_EXPANSION_POINTER_COPY == O_BASIC_POINTER_COPY)
    else $error("pointer copies differ");

endmodule
`default_nettype wire

// >>> verif/csd_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

module csd_seq_model (
  input  wire logic [8:0] i_pointer,
  input  wire logic       i_hold,
  output logic [8:0]      o_pointer_next
);
  // Stall repeats the pointer, otherwise steps on
  assign o_pointer_next = i_hold ? i_pointer : i_pointer + 9'h001;
endmodule

`default_nettype wire

// >>> verif/test_csd_core.sv
`timescale 1ns/1ps
`default_nettype none

module test_csd_core;
  typedef struct {int t; int k; logic [31:0] e; logic [31:0] m;} csd_note_s;
  logic        I_CLK_SYS, I_RST_N, I_STACK_REF, I_IR_LOAD, I_PS_LOAD_DMUX, I_PS_LOAD_CC, I_PS_TO_BUS;
  logic        I_PS_TO_RD, I_BUS_ERROR, I_POWER_UP_RESTART, I_CONSOLE_INIT, AVS_READ, AVS_WRITE;
  logic        AVS_WAITREQUEST, O_IRQ, O_SEL_PS, O_SEL_SLR, O_SEL_SCRATCH, O_SEL_SWITCH, O_D_ZERO;
  logic        O_STACK_OVERFLOW_FLAG, O_STACK_OVERFLOW_HALT, O_BUS_D_OE, O_BUS_RD_OE, seq_hold;
  logic        O_FORCED_POINTER_LOAD, O_UWORD_LOAD, O_DBL_OP, O_SGL_OP, O_BRANCH_OP, O_BYTE_OP, O_BRANCH_COND;
  logic [15:0] I_DMUX_DATA, I_D_REG, O_DATA_DISPLAY, O_INSTRUCTION_WORD, v, c;
  logic [17:0] I_BUS_ADDR;
  logic [8:0]  I_POINTER_NEXT, O_BASIC_POINTER_COPY, O_EXPANSION_POINTER_COPY, O_PREVIOUS_POINTER_LATCH, vec;
  logic [7:0]  I_STACK_LIMIT, O_IR_BRANCH_OFFSET, O_PROCESSOR_STATUS_WORD, O_BUS_D, O_BUS_RD;
  logic [3:0]  I_CC_IN, AVS_ADDRESS, O_ALU_FUNC;
  logic [2:0]  O_IR_SRC_REG, O_IR_DST_REG, O_BRANCH_TEST_SELECT;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [17:0] adr [5] = '{18'h3FFFE, 18'h3FFFC, 18'h3FFC0, 18'h3FF78, 18'h00400};
  string       kn [12] = '{"display", "zero", "select", "overflow", "pointer", "previous", "force", "instr",
                           "status", "gate", "irq", "decode"};
  csd_note_s   tq[$];
  logic [31:0] rq[$];
  int          cyc = 0;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          r, i;

  csd_core u_csd_core (
    .I_CLK_SYS, .I_RST_N, .I_DMUX_DATA, .I_D_REG, .I_BUS_ADDR, .I_STACK_REF, .I_STACK_LIMIT,
    .I_POINTER_NEXT, .I_IR_LOAD, .I_PS_LOAD_DMUX, .I_PS_LOAD_CC, .I_CC_IN, .I_PS_TO_BUS, .I_PS_TO_RD,
    .I_BUS_ERROR, .I_POWER_UP_RESTART, .I_CONSOLE_INIT, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_READDATA, .AVS_WAITREQUEST, .O_IRQ, .O_DATA_DISPLAY, .O_SEL_PS, .O_SEL_SLR, .O_SEL_SCRATCH,
    .O_SEL_SWITCH, .O_STACK_OVERFLOW_FLAG, .O_STACK_OVERFLOW_HALT, .O_D_ZERO, .O_BASIC_POINTER_COPY,
    .O_EXPANSION_POINTER_COPY, .O_PREVIOUS_POINTER_LATCH, .O_INSTRUCTION_WORD, .O_IR_SRC_REG, .O_IR_DST_REG,
    .O_IR_BRANCH_OFFSET, .O_DBL_OP, .O_SGL_OP, .O_BRANCH_OP, .O_BYTE_OP, .O_ALU_FUNC,
    .O_BRANCH_TEST_SELECT, .O_BRANCH_COND, .O_PROCESSOR_STATUS_WORD, .O_BUS_D, .O_BUS_D_OE, .O_BUS_RD,
    .O_BUS_RD_OE, .O_FORCED_POINTER_LOAD, .O_UWORD_LOAD);

  csd_seq_model u_csd_seq_model (.i_pointer(O_BASIC_POINTER_COPY), .i_hold(seq_hold), .o_pointer_next(I_POINTER_NEXT));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  function automatic logic [31:0] port_val(input int k);
    case (k)
      0: return 32'(O_DATA_DISPLAY);
      1: return 32'(O_D_ZERO);
      2: return 32'({O_SEL_PS, O_SEL_SLR, O_SEL_SCRATCH, O_SEL_SWITCH});
      3: return 32'({O_STACK_OVERFLOW_FLAG, O_STACK_OVERFLOW_HALT});
      4: return 32'({O_BASIC_POINTER_COPY, O_EXPANSION_POINTER_COPY});
      5: return 32'(O_PREVIOUS_POINTER_LATCH);
      6: return 32'({O_FORCED_POINTER_LOAD, O_UWORD_LOAD});
      7: return 32'({O_IR_SRC_REG, O_IR_DST_REG, O_IR_BRANCH_OFFSET, O_INSTRUCTION_WORD});
      8: return 32'(O_PROCESSOR_STATUS_WORD);
      9: return 32'({O_BUS_D_OE, O_BUS_D, O_BUS_RD_OE, O_BUS_RD});
      11: return 32'({O_DBL_OP, O_SGL_OP, O_BRANCH_OP, O_BYTE_OP, O_ALU_FUNC, O_BRANCH_TEST_SELECT, O_BRANCH_COND});
      default: return 32'(O_IRQ);
    endcase
  endfunction

  task automatic cmp_port(input int k, input logic [31:0] e, m);
    samples_checked++;
    if ((port_val(k) & m) !== (e & m)) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", kn[k], e & m, port_val(k) & m);
    end
  endtask

  task automatic cmp_read(input logic [31:0] e, a);
    samples_checked++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch readdata expected %h seen %h", e, a);
    end
  endtask

  task automatic print_verdict();
    num_errors += tq.size() + rq.size();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge I_CLK_SYS) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && rq.size() > 0) cmp_read(rq.pop_front(), AVS_READDATA);
  end

  always @(negedge I_CLK_SYS) begin
    cyc++;
    while (tq.size() > 0 && tq[0].t <= cyc) begin
      cmp_port(tq[0].k, tq[0].e, tq[0].m);
      void'(tq.pop_front());
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic note(input int dt, k, input logic [31:0] e, m = 32'hFFFFFFFF);
    tq.push_back('{cyc + dt, k, e, m});
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, e);
    int n;
    @(posedge I_CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    if (!w) rq.push_back(e);
    for (n = 0; n < 20; n++) begin
      @(posedge I_CLK_SYS);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (n == 20) begin
      num_errors++;
      print_verdict();
    end
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  initial begin
    I_CLK_SYS = 1'b0;
    forever #5 I_CLK_SYS = ~I_CLK_SYS;
  end

  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end

  initial begin
    {I_RST_N, I_STACK_REF, I_IR_LOAD, I_PS_LOAD_DMUX, I_PS_LOAD_CC, I_PS_TO_BUS, I_PS_TO_RD} = '0;
    {I_BUS_ERROR, I_POWER_UP_RESTART, I_CONSOLE_INIT, AVS_READ, AVS_WRITE, seq_hold} = '0;
    {I_DMUX_DATA, I_D_REG, I_BUS_ADDR, I_STACK_LIMIT, I_CC_IN, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    r = $urandom(46581);
    repeat (12) @(posedge I_CLK_SYS);
    note(1, 0, 32'h0000FFFF);
    I_RST_N <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 32'h0);
    bus(1'b0, 4'h8, 32'h0, 32'h3);
    bus(1'b1, 4'h4, 32'h15, 32'h0);
    bus(1'b0, 4'h4, 32'h0, 32'h15);
    bus(1'b1, 4'h4, 32'h0, 32'h0);
    bus(1'b1, 4'h2, 32'hFF, 32'h0);
    bus(1'b0, 4'h2, 32'h0, 32'h0);
    for (i = 0; i < 5; i++) begin
      @(posedge I_CLK_SYS);
      I_BUS_ADDR <= adr[i] + ((i == 2) ? 18'($urandom_range(15)) : 18'h00000);
      note(1, 2, 32'(4'h8 >> i));
    end
    for (i = 0; i < 8; i++) begin
      @(posedge I_CLK_SYS);
      v = 16'($urandom);
      c = i[0] ? 16'h0000 : 16'($urandom);
      I_DMUX_DATA <= v;
      I_D_REG <= c;
      seq_hold <= 1'($urandom);
      note(1, 1, 32'(c == 16'h0000));
      note(2, 0, {16'h0000, ~v});
    end
    @(posedge I_CLK_SYS);
    I_BUS_ADDR <= 18'h08000;
    I_STACK_REF <= 1'b1;
    seq_hold <= 1'b0;
    note(1, 3, 32'h0);
    @(posedge I_CLK_SYS);
    v = 16'($urandom);
    c = 16'($urandom);
    I_DMUX_DATA <= v;
    I_CC_IN <= c[3:0];
    {I_IR_LOAD, I_PS_LOAD_DMUX, I_PS_LOAD_CC} <= 3'b111;
    note(2, 7, 32'({v[8:6], v[2:0], v[7:0], v}));
    note(2, 8, 32'(v[7:0]));
    @(posedge I_CLK_SYS);
    I_DMUX_DATA <= ~v;
    {I_IR_LOAD, I_PS_LOAD_DMUX, I_PS_TO_BUS} <= 3'b001;
    note(1, 9, 32'({1'b1, v[7:0], 1'b0, 8'h00}));
    note(2, 7, 32'({v[8:6], v[2:0], v[7:0], v}));
    note(2, 8, 32'(c[3:0]), 32'h0000000F);
    @(posedge I_CLK_SYS);
    {I_PS_LOAD_CC, I_PS_TO_BUS, I_PS_TO_RD, I_IR_LOAD} <= 4'b0011;
    I_DMUX_DATA <= 16'h8A00;
    note(1, 9, 32'({10'h001, 4'h0, c[3:0]}), 32'h0003FF0F);
    note(2, 11, 32'h00000580);
    // Each forcing event in turn, then its sticky status
    for (i = 0; i < 4; i++) begin
      @(posedge I_CLK_SYS);
      I_PS_TO_RD <= 1'b0;
      I_IR_LOAD <= 1'b0;
      case (i)
        0: I_POWER_UP_RESTART <= 1'b1;
        1: I_CONSOLE_INIT <= 1'b1;
        2: I_BUS_ERROR <= 1'b1;
        default: I_BUS_ADDR <= 18'h00000;
      endcase
      r = (i < 2) ? 3 : 1;
      vec = 9'h001 << i;
      if (i == 3) note(1, 3, 32'h1, 32'h1);
      note(1 + r, 4, 32'({vec, vec}));
      note(1 + r, 6, 32'h2);
      note(2 + r, 6, 32'h1);
      note(2 + r, 5, 32'(vec));
      note(2 + r, 4, 32'({vec + 9'h001, vec + 9'h001}));
      repeat (r + 4) @(posedge I_CLK_SYS);
      {I_POWER_UP_RESTART, I_CONSOLE_INIT, I_BUS_ERROR} <= 3'b000;
      I_BUS_ADDR <= 18'h08000;
      bus(1'b1, 4'h4, 32'(1 << i), 32'h0);
      note(1, 10, 32'h1);
      bus(1'b0, 4'h0, 32'h0, (i == 3) ? 32'h18 : 32'(1 << i));
      bus(1'b1, 4'h0, 32'h1F, 32'h0);
      note(1, 10, 32'h0);
      bus(1'b1, 4'h4, 32'h0, 32'h0);
    end
    repeat (4) @(posedge I_CLK_SYS);
    print_verdict();
  end
endmodule

`default_nettype wire
